/* include/fan_ctrl_pkg.sv */
// Shared constants, types and decode functions of the two-fan speed controller.
// Assumes one 125 MHz clock and configuration held outside as plain ports.
package fan_ctrl_pkg;

  // Clocking and time bases
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned INT_OSC_HZ  = 32_000;
  localparam int unsigned OSC_CYCLES  = CLK_HZ / INT_OSC_HZ;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int unsigned WDOG_TIME_S = 4;
  localparam logic [11:0] WDOG_MS     = 12'(WDOG_TIME_S * MS_PER_S);

  // Widths and counts
  localparam int NUM_FANS = 2;
  localparam int READ_W   = 16;

  // Drive levels, target and reset values
  localparam logic [7:0]        DRIVE_OFF   = 8'h00;
  localparam logic [7:0]        DRIVE_FULL  = 8'hFF;
  localparam logic [7:0]        TARGET_OFF  = 8'hFF;
  localparam logic [READ_W-1:0] READING_RST = 16'hFFFF;
  localparam logic [11:0]       TMR_RST     = 12'h000;

  // Per-channel control state, Gray along run -> spin -> run
  typedef enum logic {
    CH_RUN  = 1'b0,
    CH_SPIN = 1'b1
  } chan_state_type;

  // Update period in ms: 100 ms up to 1.6 s
  function automatic logic [11:0] update_ms(input logic [2:0] sel);
    case (sel)
      3'h0:    return 12'h064;
      3'h1:    return 12'h0C8;
      3'h2:    return 12'h12C;
      3'h3:    return 12'h190;
      3'h4:    return 12'h1F4;
      3'h5:    return 12'h320;
      3'h6:    return 12'h4B0;
      default: return 12'h640;
    endcase
  endfunction

  // Total spin-up time in ms
  function automatic logic [11:0] spin_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    return 12'h0FA;
      2'h1:    return 12'h1F4;
      2'h2:    return 12'h3E8;
      default: return 12'h7D0;
    endcase
  endfunction

  // Spin-up hold level, 30 % to 65 % of full scale in 5 % steps
  function automatic logic [7:0] spin_level(input logic [2:0] sel);
    case (sel)
      3'h0:    return 8'h4D;
      3'h1:    return 8'h59;
      3'h2:    return 8'h66;
      3'h3:    return 8'h73;
      3'h4:    return 8'h80;
      3'h5:    return 8'h8C;
      3'h6:    return 8'h99;
      default: return 8'hA6;
    endcase
  endfunction

  // Tach edges per measurement: 3, 5, 7 or 9
  function automatic logic [3:0] edges_needed(input logic [1:0] sel);
    return {1'b0, sel, 1'b1} + 4'h2;
  endfunction

  // Move cur toward want by no more than step counts
  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] want,
                                         input logic [4:0] step);
    logic [8:0] gap;
    gap = (want > cur) ? {1'b0, want - cur} : {1'b0, cur - want};
    if (gap <= {4'h0, step}) return want;
    return (want > cur) ? cur + {3'h0, step} : cur - {3'h0, step};
  endfunction

endpackage

/* hw/tach_period_meter.sv */
// Tach period meter: counts reference ticks across a chosen number of tach edges.
// Assumes ref_tick_i is a one-cycle pulse on clk_i; tach_i is an asynchronous pin.
`timescale 1ns/1ps
module tach_period_meter
  import fan_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Inputs
  input  wire logic              tach_i,
  input  wire logic              ref_tick_i,
  input  wire logic [1:0]        edges_sel_i,
  // Result
  output logic      [READ_W-1:0] reading_o
);

  typedef struct packed {
    logic [1:0]        sync;
    logic              prev;
    logic [3:0]        edges;
    logic [READ_W-1:0] cnt;
    logic [READ_W-1:0] reading;
  } meter_type;

  meter_type s_reg;
  meter_type s_next;
  logic      rise;

  // Free-running measurement, never gated by the drive level
  always_comb begin
    s_next      = s_reg;
    s_next.sync = {s_reg.sync[0], tach_i};
    s_next.prev = s_reg.sync[1];
    rise        = s_reg.sync[1] && !s_reg.prev;
    if (ref_tick_i && s_reg.cnt != READING_RST) begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
    // A stopped fan never closes a window, so a full counter publishes at once
    if (s_reg.cnt == READING_RST) begin
      s_next.reading = READING_RST; // R06
    end
    if (rise) begin
      if (s_reg.edges + 4'h1 >= edges_needed(edges_sel_i)) begin
        s_next.reading = s_reg.cnt; // R05
        s_next.cnt     = '0;
        s_next.edges   = 4'h1;
      end else begin
        s_next.edges = s_reg.edges + 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg         <= '0;
      // Tach idles high, so a parked fan gives no false edge after reset
      s_reg.sync    <= '1;
      s_reg.prev    <= 1'b1;
      s_reg.reading <= READING_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reading_o = s_reg.reading;

endmodule

/* hw/fan_speed_ctrl.sv */
// Two-fan speed controller: tach reference, watchdog, spin-up, ramp limit and
// closed-loop drive. Register accesses arrive as decoded strobes and levels;
// bus_busy_i is high for the length of each host bus transaction.
//
// Function
// R01: Two independent control loops, each owning one fan drive output.
// R02: Target is reference clocks per revolution; loop follows any rewrite.
// R03: Target high byte FFh turns that fan drive off.
// R04: Loop starts disabled; software tunes then sets the loop enable bit.
// R05: Tach reading counts reference clocks across a programmed number of edges.
// R06: Measurement ignores drive level; low direct drive may flag stall.
// R07: Reading above valid count flags stall; loop keeps retrying restart.
// R08: Entering direct mode or spin-up masks stall for the spin-up time.
// R09: Direct mode checks stall always; loop mode only at update ticks.
// R10: Full drive still outside band of target sets drive-fail and alert.
// R11: Tach reference is external pin clock or internal oscillator.
// R12: As clock source, use internal oscillator and drive it out push-pull.
// R13: Direct mode setting change from 00h to nonzero starts spin-up.
// R14: Loop spin-up on target leaving FFh below valid, or stalled reading.
// R15: Spin-up optional full drive first quarter, then 30 to 65 % level.
// R16: Reading above valid after spin-up sets spin-fail and reruns spin-up.
// R17: Ramp limit moves drive by at most max step per update period.
// R18: Four idle seconds fire watchdog: flag, full drive, alert, loop off.
// R19: Software restores drive and loop after a watchdog event. Code keeps full drive until reset while the continuous watchdog is on.
// R20: Power-up watchdog runs once from reset; stall checks wait meanwhile.
// R21: Drive write or loop enable cancels power-up watchdog; nothing else.
// R22: Continuous watchdog restarts after every bus transaction.
// R23: Direct drive write reaches output at once unless ramp limited.
// R24: Status flags reset to zero and clear on software read.
// R25: Alert follows enabled flags and watchdog flag until cleared.
`timescale 1ns/1ps
module fan_speed_ctrl
  import fan_ctrl_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             srst_i,
  // Per-fan configuration
  input  wire logic [NUM_FANS-1:0]              loop_enable_bit_i,
  input  wire logic [NUM_FANS-1:0]              ramp_limit_enable_i,
  input  wire logic [NUM_FANS-1:0][7:0]         drive_setting_i,
  input  wire logic [NUM_FANS-1:0]              drive_write_i,
  input  wire logic [NUM_FANS-1:0][READ_W-1:0]  tach_target_i,
  input  wire logic [NUM_FANS-1:0][7:0]         valid_count_i,
  input  wire logic [NUM_FANS-1:0][7:0]         min_drive_i,
  input  wire logic [NUM_FANS-1:0][4:0]         max_step_i,
  input  wire logic [NUM_FANS-1:0][READ_W-1:0]  drive_fail_band_i,
  input  wire logic [NUM_FANS-1:0][2:0]         update_sel_i,
  input  wire logic [NUM_FANS-1:0][1:0]         edges_sel_i,
  input  wire logic [NUM_FANS-1:0][1:0]         spin_time_sel_i,
  input  wire logic [NUM_FANS-1:0][2:0]         spin_level_sel_i,
  input  wire logic [NUM_FANS-1:0]              spin_full_i,
  input  wire logic [NUM_FANS-1:0]              flag_enable_i,
  // Device configuration and bus activity
  input  wire logic                             clk_ext_sel_i,
  input  wire logic                             clk_out_en_i,
  input  wire logic                             wdog_continuous_i,
  input  wire logic                             bus_busy_i,
  // Read strobes of the clear-on-read status registers
  input  wire logic                             stall_rd_i,
  input  wire logic                             spin_rd_i,
  input  wire logic                             drive_fail_rd_i,
  input  wire logic                             status_rd_i,
  // Pins
  input  wire logic [NUM_FANS-1:0]              tach_input_i,
  input  wire logic                             clk_pin_i,
  output logic                                  clk_pin_o,
  output logic                                  clk_pin_oe_o,
  // Drive and status
  output logic      [NUM_FANS-1:0][7:0]         drive_o,
  output logic      [NUM_FANS-1:0][READ_W-1:0]  tach_reading_o,
  output logic      [NUM_FANS-1:0]              closed_loop_speed_mode_o,
  output logic      [NUM_FANS-1:0]              stall_o,
  output logic      [NUM_FANS-1:0]              spin_fail_o,
  output logic      [NUM_FANS-1:0]              drive_fail_o,
  output logic                                  wdog_flag_o,
  output logic                                  alert_o
);

  localparam logic [16:0] MS_LAST  = 17'(MS_CYCLES_P - 1);
  localparam logic [11:0] OSC_HALF = 12'(OSC_CYCLES / 2 - 1);

  // Per-channel state
  typedef struct packed {
    chan_state_type state;
    logic [7:0]     setting;
    logic [7:0]     drive;
    logic [11:0]    upd_tmr;
    logic [11:0]    spin_tmr;
    logic [11:0]    mask_tmr;
    logic           stall;
    logic           spin_fail;
    logic           drive_fail;
    logic           loop_kill;
    logic           direct_q;
    logic           tgt_off_q;
  } chan_type;

  // Whole-block state
  typedef struct packed {
    chan_type [NUM_FANS-1:0] ch;
    logic [1:0]              ext_sync;
    logic                    ext_prev;
    logic [11:0]             osc_cnt;
    logic                    osc_q;
    logic [16:0]             ms_cnt;
    logic [11:0]             wd_ms;
    logic                    pu_active;
    logic                    forced;
    logic                    wd_flag;
    logic [NUM_FANS-1:0]     loop_en_q;
    logic                    alert;
  } ctrl_type;

  ctrl_type                          s_reg;
  ctrl_type                          s_next;
  logic     [NUM_FANS-1:0][READ_W-1:0] reading;
  logic                              ms_tick;
  logic                              osc_tick;
  logic                              ext_tick;
  logic                              ref_tick;

  // Time bases and tach reference selection
  assign ms_tick  = s_reg.ms_cnt == MS_LAST;
  assign osc_tick = s_reg.osc_cnt == OSC_HALF;
  assign ext_tick = s_reg.ext_sync[1] && !s_reg.ext_prev;
  // Driving the pin out forces the internal oscillator as reference
  assign ref_tick = (clk_ext_sel_i && !clk_out_en_i) ? ext_tick : (osc_tick && !s_reg.osc_q); // R11 R12

  // One period meter per fan
  for (genvar g = 0; g < NUM_FANS; g++) begin : g_meter
    tach_period_meter u_meter (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .tach_i      (tach_input_i[g]),
      .ref_tick_i  (ref_tick),
      .edges_sel_i (edges_sel_i[g]),
      .reading_o   (reading[g])
    );
  end

  // Next-state logic for watchdog and both channels
  always_comb begin
    chan_type   c;
    logic       cancel;
    logic       fire;
    logic       loop_on;
    logic       slow;
    logic       upd;
    logic       start;
    logic       tgt_off;
    logic [7:0] want;
    logic [11:0] spin_total;
    logic       flags;
    c          = s_reg.ch[0];
    cancel     = 1'b0;
    fire       = 1'b0;
    loop_on    = 1'b0;
    slow       = 1'b0;
    upd        = 1'b0;
    start      = 1'b0;
    tgt_off    = 1'b0;
    want       = DRIVE_OFF;
    spin_total = TMR_RST;
    flags      = 1'b0;
    s_next     = s_reg;

    // Reference clock: external pin through two flops, internal by division
    s_next.ext_sync = {s_reg.ext_sync[0], clk_pin_i};
    s_next.ext_prev = s_reg.ext_sync[1];
    s_next.osc_cnt  = osc_tick ? TMR_RST : s_reg.osc_cnt + 12'h001;
    if (osc_tick) begin
      s_next.osc_q = ~s_reg.osc_q;
    end
    s_next.ms_cnt = ms_tick ? 17'h0_0000 : s_reg.ms_cnt + 17'h0_0001;

    // Watchdog cancel: only a drive write or a fresh loop enable counts
    s_next.loop_en_q = loop_enable_bit_i;
    cancel = (|drive_write_i) || (|(loop_enable_bit_i & ~s_reg.loop_en_q));
    if (cancel) begin
      s_next.pu_active = 1'b0; // R21
    end
    if (status_rd_i) begin
      s_next.wd_flag = 1'b0; // R24
    end
    if (!wdog_continuous_i && cancel) begin
      s_next.forced = 1'b0;
    end
    // Held clear while busy, so a fresh interval starts when traffic ends
    if (!(s_reg.pu_active || wdog_continuous_i) || bus_busy_i) begin
      s_next.wd_ms = TMR_RST; // R22
    end else if (ms_tick) begin
      if (s_reg.wd_ms == WDOG_MS - 12'h001) begin
        fire         = 1'b1;
        s_next.wd_ms = TMR_RST;
      end else begin
        s_next.wd_ms = s_reg.wd_ms + 12'h001;
      end
    end
    // Firing wins over a cancel or read in the same cycle
    if (fire) begin
      s_next.wd_flag   = 1'b1; // R18
      s_next.forced    = 1'b1; // R18
      s_next.pu_active = 1'b0; // R20
    end

    for (int i = 0; i < NUM_FANS; i++) begin
      c     = s_reg.ch[i];
      start = 1'b0;
      // Clear-on-read first so that a set below in the same cycle wins
      if (stall_rd_i) begin
        c.stall = 1'b0; // R24
      end
      if (spin_rd_i) begin
        c.spin_fail = 1'b0; // R24
      end
      if (drive_fail_rd_i) begin
        c.drive_fail = 1'b0; // R24
      end
      // Loop stays off after a watchdog event until software enables it again
      if (loop_enable_bit_i[i] && !s_reg.loop_en_q[i]) begin
        c.loop_kill = 1'b0; // R19
      end
      if (fire) begin
        c.loop_kill = 1'b1; // R18
      end
      loop_on    = loop_enable_bit_i[i] && !c.loop_kill; // R04
      slow       = reading[i][READ_W-1:8] > valid_count_i[i];
      spin_total = spin_ms(spin_time_sel_i[i]);
      upd        = ms_tick && (c.upd_tmr == TMR_RST);
      tgt_off    = tach_target_i[i][READ_W-1:8] == TARGET_OFF;

      // Update period and stall mask timers
      if (ms_tick) begin
        c.upd_tmr = upd ? update_ms(update_sel_i[i]) - 12'h001 : c.upd_tmr - 12'h001;
        if (c.mask_tmr != TMR_RST) begin
          c.mask_tmr = c.mask_tmr - 12'h001;
        end
      end

      // Entering direct mode restores the last written setting
      if (!loop_on && !c.direct_q) begin
        c.mask_tmr = spin_total; // R08
        c.drive    = c.setting;
        c.state    = CH_RUN;
      end
      c.direct_q = !loop_on;

      // Setting writes are refused in loop mode, where the setting is read only
      if (drive_write_i[i] && !loop_on) begin
        if (c.setting == DRIVE_OFF && drive_setting_i[i] != DRIVE_OFF) begin
          start = 1'b1; // R13
        end
        c.setting = drive_setting_i[i];
      end
      if (loop_on && c.tgt_off_q && !tgt_off
          && tach_target_i[i][READ_W-1:8] < valid_count_i[i]) begin
        start = 1'b1; // R14
      end
      c.tgt_off_q = tgt_off;

      if (c.state == CH_RUN) begin
        if (!loop_on) begin
          want = c.setting;
          if (!ramp_limit_enable_i[i]) begin
            c.drive = want; // R23
          end else if (upd) begin
            c.drive = step_to(c.drive, want, max_step_i[i]); // R17
          end
          // Continuous check, quiet during the mask and the power-up watchdog
          if (slow && c.mask_tmr == TMR_RST && !s_reg.pu_active) begin
            c.stall = 1'b1; // R09 R06 R20
          end
        end else if (tgt_off) begin
          c.drive = DRIVE_OFF; // R03
        end else if (upd) begin
          if (slow) begin
            if (!s_reg.pu_active) begin
              c.stall = 1'b1; // R07 R09 R20
            end
            start = 1'b1; // R07 R14
          end else begin
            // Larger count means slower fan, so more drive
            if (reading[i] > tach_target_i[i]) begin
              want = DRIVE_FULL;
            end else if (reading[i] < tach_target_i[i]) begin
              want = min_drive_i[i];
            end else begin
              want = c.drive;
            end
            c.drive = step_to(c.drive, want, max_step_i[i]); // R02 R17
            if (c.drive == DRIVE_FULL && {1'b0, reading[i]}
                > {1'b0, tach_target_i[i]} + {1'b0, drive_fail_band_i[i]}) begin
              c.drive_fail = 1'b1; // R10
            end
          end
        end
      end else begin
        // Optional full kick for the first quarter, then the hold level
        if (spin_full_i[i] && c.spin_tmr > spin_total - (spin_total >> 2)) begin
          c.drive = DRIVE_FULL; // R15
        end else begin
          c.drive = spin_level(spin_level_sel_i[i]); // R15
        end
        if (ms_tick) begin
          if (c.spin_tmr <= 12'h001) begin
            if (slow) begin
              c.spin_fail = 1'b1; // R16
              start       = 1'b1; // R16
            end else begin
              c.state = CH_RUN;
            end
          end else begin
            c.spin_tmr = c.spin_tmr - 12'h001;
          end
        end
      end

      // Spin-up start or restart; stall stays masked for its whole length
      if (start) begin
        c.state    = CH_SPIN;
        c.spin_tmr = spin_total;
        c.mask_tmr = spin_total; // R08
      end
      // Watchdog override holds full scale until a drive write or loop enable while the continuous watchdog is off
      if (s_next.forced) begin
        c.drive = DRIVE_FULL; // R18
      end
      flags = flags || (flag_enable_i[i] && (c.stall || c.spin_fail || c.drive_fail));
      s_next.ch[i] = c; // R01
    end

    // Alert is registered from the next flag values
    s_next.alert = s_next.wd_flag || flags; // R25 R10 R18
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg           <= '0;
      s_reg.pu_active <= 1'b1; // R20
    end else begin
      s_reg <= s_next;
    end
  end

  // Clock pin driven push-pull only when this device is the source
  assign clk_pin_o    = s_reg.osc_q;
  assign clk_pin_oe_o = clk_out_en_i; // R12

  // Outputs straight from state
  for (genvar g = 0; g < NUM_FANS; g++) begin : g_out
    assign drive_o[g]                  = s_reg.ch[g].drive;
    assign tach_reading_o[g]           = reading[g];
    assign closed_loop_speed_mode_o[g] = !s_reg.ch[g].direct_q;
    assign stall_o[g]                  = s_reg.ch[g].stall;
    assign spin_fail_o[g]              = s_reg.ch[g].spin_fail;
    assign drive_fail_o[g]             = s_reg.ch[g].drive_fail;
  end
  assign wdog_flag_o = s_reg.wd_flag;
  assign alert_o     = s_reg.alert;

endmodule

/* dv/fan_model.sv */
// Behavioural four-wire fan: PWM level in, tach square wave out.
// Assumes one bench clock; tach pull-up holds the line high when stopped.
`timescale 1ns/1ps
module fan_model (
  // Clock
  input  wire logic       clk_i,
  // Drive in, tach out
  input  wire logic [7:0] drive_i,
  output logic            tach_o
);
  logic [15:0] cnt_reg = 16'h0000;
  initial tach_o = 1'b1;
  // Half period shrinks as drive rises; zero drive parks the line at pull-up
  always @(posedge clk_i) begin
    if (drive_i == 8'h00) begin
      tach_o <= 1'b1;
    end else if (cnt_reg >= 16'h8000 / drive_i) begin
      cnt_reg <= 16'h0000;
      tach_o  <= ~tach_o;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule

/* dv/fan_speed_ctrl_properties.sv */
// Port relations of the fan controller, checked over time.
// Bound to every fan_speed_ctrl; watches fan 0 where a rule is per channel.
`timescale 1ns/1ps
module fan_speed_ctrl_properties
  import fan_ctrl_pkg::*;
(
  input wire logic                            clk_i,
  input wire logic                            srst_i,
  input wire logic [NUM_FANS-1:0]             loop_enable_bit_i,
  input wire logic [NUM_FANS-1:0]             ramp_limit_enable_i,
  input wire logic [NUM_FANS-1:0][7:0]        drive_setting_i,
  input wire logic [NUM_FANS-1:0]             drive_write_i,
  input wire logic [NUM_FANS-1:0][READ_W-1:0] tach_target_i,
  input wire logic [NUM_FANS-1:0][7:0]        valid_count_i,
  input wire logic [NUM_FANS-1:0]             flag_enable_i,
  input wire logic                            clk_out_en_i,
  input wire logic                            clk_pin_oe_o,
  input wire logic [NUM_FANS-1:0][7:0]        drive_o,
  input wire logic [NUM_FANS-1:0][READ_W-1:0] tach_reading_o,
  input wire logic [NUM_FANS-1:0]             closed_loop_speed_mode_o,
  input wire logic [NUM_FANS-1:0]             stall_o,
  input wire logic [NUM_FANS-1:0]             spin_fail_o,
  input wire logic                            wdog_flag_o,
  input wire logic                            alert_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Watchdog, flag causes, target off, direct writes and alert
  chk_oe_follow: assert property (clk_pin_oe_o == clk_out_en_i)
    else $error("clock pin enable differs from config");
  chk_wdog_full: assert property ($rose(wdog_flag_o) |-> ##[0:1] drive_o == '1)
    else $error("watchdog did not force full drive");
  chk_wdog_loopoff: assert property ($rose(wdog_flag_o) |-> ##[0:1]
    (alert_o && closed_loop_speed_mode_o == '0)) else $error("watchdog left loop or no alert");
  chk_stall_cause: assert property ($rose(stall_o[0]) |->
    $past(tach_reading_o[0][15:8]) > $past(valid_count_i[0])) else $error("stall without slow tach");
  chk_spin_cause: assert property ($rose(spin_fail_o[0]) |->
    $past(tach_reading_o[0][15:8]) > $past(valid_count_i[0])) else $error("spin fail unjustified");
  chk_target_off: assert property ((closed_loop_speed_mode_o[0] && !wdog_flag_o &&
    tach_target_i[0][15:8] == TARGET_OFF)[*3] |-> drive_o[0] == DRIVE_OFF)
    else $error("fan not off at target off");
  chk_direct_write: assert property ((drive_write_i[0] && !loop_enable_bit_i[0] &&
    !closed_loop_speed_mode_o[0] && !ramp_limit_enable_i[0] && !wdog_flag_o &&
    drive_o[0] != DRIVE_OFF && drive_setting_i[0] != DRIVE_OFF)
    |=> drive_o[0] == $past(drive_setting_i[0])) else $error("direct write not applied");
  chk_alert_hold: assert property (((stall_o[0] && flag_enable_i[0]) || wdog_flag_o)[*2]
    |-> alert_o) else $error("alert low with flag set");
  cover property ($rose(wdog_flag_o));
  cover property ($rose(stall_o[0]));
  cover property ($rose(closed_loop_speed_mode_o[0]));
endmodule
bind fan_speed_ctrl fan_speed_ctrl_properties i_props (.clk_i, .srst_i, .loop_enable_bit_i,
  .ramp_limit_enable_i, .drive_setting_i, .drive_write_i, .tach_target_i, .valid_count_i,
  .flag_enable_i, .clk_out_en_i, .clk_pin_oe_o, .drive_o, .tach_reading_o,
  .closed_loop_speed_mode_o, .stall_o, .spin_fail_o, .wdog_flag_o, .alert_o);

/* dv/rpm_fan_speed_controller_bench.sv */
// Self-checking bench of the two-fan controller with a fan model per channel.
// Assumes the package is compiled first; fast external reference on the clock pin.
`timescale 1ns/1ps
module rpm_fan_speed_controller_bench;
  import fan_ctrl_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, clk_pin_i = 1'b0, clk_ext_sel_i = 1'b1;
  logic clk_out_en_i = 1'b0, wdog_continuous_i = 1'b0, bus_busy_i = 1'b0;
  logic stall_rd_i = 1'b0, spin_rd_i = 1'b0, drive_fail_rd_i = 1'b0, status_rd_i = 1'b0;
  logic [1:0] loop_enable_bit_i = '0, ramp_limit_enable_i = '0, drive_write_i = '0;
  logic [1:0] spin_full_i = '1, flag_enable_i = 2'b01;
  logic [1:0][7:0] drive_setting_i = '0, valid_count_i = {8'hFF, 8'h01}, min_drive_i = '1;
  logic [1:0][15:0] tach_target_i = '1, drive_fail_band_i = '0;
  logic [1:0][4:0] max_step_i = '1;
  logic [1:0][2:0] update_sel_i = '0, spin_level_sel_i = '0;
  logic [1:0][1:0] edges_sel_i = '0, spin_time_sel_i = '0;
  logic clk_pin_oe_o, wdog_flag_o, alert_o;
  logic [1:0] closed_loop_speed_mode_o, stall_o, spin_fail_o, drive_fail_o;
  logic [1:0][7:0] drive_o;
  logic [1:0][15:0] tach_reading_o;
  wire [1:0] tach_input_i;
  int seed = 32'he935, fail_count = 0, num_checks = 0;

  fan_speed_ctrl #(.MS_CYCLES_P(10)) i_dut (.clk_i, .srst_i, .loop_enable_bit_i,
    .ramp_limit_enable_i, .drive_setting_i, .drive_write_i, .tach_target_i, .valid_count_i,
    .min_drive_i, .max_step_i, .drive_fail_band_i, .update_sel_i, .edges_sel_i,
    .spin_time_sel_i, .spin_level_sel_i, .spin_full_i, .flag_enable_i, .clk_ext_sel_i,
    .clk_out_en_i, .wdog_continuous_i, .bus_busy_i, .stall_rd_i, .spin_rd_i,
    .drive_fail_rd_i, .status_rd_i, .tach_input_i, .clk_pin_i, .clk_pin_o(),
    .clk_pin_oe_o, .drive_o, .tach_reading_o, .closed_loop_speed_mode_o, .stall_o,
    .spin_fail_o, .drive_fail_o, .wdog_flag_o, .alert_o);
  fan_model i_fan0 (.clk_i, .drive_i(drive_o[0]), .tach_o(tach_input_i[0]));
  fan_model i_fan1 (.clk_i, .drive_i(drive_o[1]), .tach_o(tach_input_i[1]));

  // Main clock, and a fast reference on the pin to keep tach windows short
  always #4 clk_i = ~clk_i;
  always #16 clk_pin_i = ~clk_pin_i;

  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    num_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic write0(input logic [7:0] v);
    drive_setting_i[0] = v;
    drive_write_i[0] = 1'b1;
    tick(1);
    drive_write_i[0] = 1'b0;
    tick(1);
  endtask
  task automatic stop_test;
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Spin hold level: 30 % plus 5 % per step, rounded to full-scale counts
  function automatic logic [7:0] lvl(input logic [2:0] s);
    return 8'((255 * (30 + 5 * s) + 50) / 100);
  endfunction

  // Hang guard, a little beyond the planned run length
  initial begin
    #800_000;
    fail_count++;
    stop_test();
  end

  // Reset, spin-up, direct writes, ramp, stall, loop and watchdog in turn
  initial begin
    logic [7:0] v;
    clk_out_en_i = 1'b1;
    tick(2);
    check(16'h0001, 16'(clk_pin_oe_o));
    clk_out_en_i = 1'b0;
    tick(14);
    srst_i = 1'b0;
    tick(2);
    check(16'h0000, 16'(drive_o));
    check(16'h0000, 16'({stall_o, spin_fail_o, drive_fail_o, wdog_flag_o, alert_o}));
    spin_level_sel_i[0] = 3'($random(seed));
    write0(8'h80);
    tick(2);
    check(16'h00FF, 16'(drive_o[0]));
    tick(1000);
    check(16'(lvl(spin_level_sel_i[0])), 16'(drive_o[0]));
    tick(2500);
    check(16'h0080, 16'(drive_o[0]));
    check(16'h0000, 16'(stall_o));
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed)) | 8'h40;
      write0(v);
      check(16'(v), 16'(drive_o[0]));
      check(16'h0000, 16'(drive_o[1]));
    end
    write0(8'h20);
    ramp_limit_enable_i[0] = 1'b1;
    max_step_i[0] = 5'(16 + ($random(seed) & 15));
    write0(8'hE0);
    check(16'h0001, 16'(drive_o[0] - 8'h20 <= max_step_i[0]));
    tick((192 / max_step_i[0] + 2) * 1000);
    check(16'h00E0, 16'(drive_o[0]));
    ramp_limit_enable_i[0] = 1'b0;
    write0(8'h18);
    tick(9000);
    check(16'h0003, 16'({stall_o[0], alert_o}));
    write0(8'h80);
    tick(8000);
    {stall_rd_i, spin_rd_i, drive_fail_rd_i} = 3'b111;
    tick(1);
    {stall_rd_i, spin_rd_i, drive_fail_rd_i} = 3'b000;
    tick(2);
    check(16'h0000, 16'({stall_o[0], alert_o}));
    check(16'h0001, 16'(tach_reading_o[0][15:8]));
    loop_enable_bit_i[0] = 1'b1;
    tick(20);
    check(16'h0100, 16'({closed_loop_speed_mode_o[0], drive_o[0]}));
    tach_target_i[0] = 16'h00C0;
    tick(3);
    check(16'h00FF, 16'(drive_o[0]));
    wdog_continuous_i = 1'b1;
    tick(20000);
    bus_busy_i = 1'b1;
    tick(3);
    bus_busy_i = 1'b0;
    tick(30000);
    check(16'h0000, 16'(wdog_flag_o));
    for (int n = 0; n < 12000 && wdog_flag_o !== 1'b1; n++) tick(1);
    check(16'hFFFF, 16'(drive_o));
    check(16'h000C, 16'({wdog_flag_o, alert_o, closed_loop_speed_mode_o}));
    status_rd_i = 1'b1;
    tick(1);
    status_rd_i = 1'b0;
    tick(2);
    check(16'h0000, 16'(wdog_flag_o));
    check(16'hFFFF, 16'(drive_o));
    wdog_continuous_i = 1'b0;
    write0(8'h40);
    check(16'h0040, 16'(drive_o));
    stop_test();
  end
endmodule
